/* File: asr_params.svh */
// constants of the angle-synchronous shift register: offsets, fields, resets, timing
//
// What this block does
// - position steps clock the register contents
// - logic network bit enters the first cell
// - speed compensation acts on register output
// - three output modes, chosen by parameter
// - mode one: common on/off compensation
// - mode two: separate on and off compensation
// - mode three: compensated on, then timed hold
// - length counted in actual-value units
// - length capped by global shift capacity
// - usable only with capacity above zero, slot free
// - mode two output undefined once off overtakes on
// - result drives output, marker or extended range
// - times in 0.1 ms units
// - each forward step loads cell zero, moves all cells
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ASR_REG_CTRL 4'h0
`define ASR_REG_CAPACITY 4'h1
`define ASR_REG_LENGTH 4'h2
`define ASR_REG_COMP_ON 4'h3
`define ASR_REG_COMP_OFF 4'h4
`define ASR_REG_ON_TIME 4'h5
`define ASR_REG_TARGET 4'h6
`define ASR_REG_STATUS 4'h7
`define ASR_REG_PERIOD 4'h8
`define ASR_REG_LEAD_ON 4'h9
`define ASR_REG_LEAD_OFF 4'ha

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ASR_CTRL_EN_BIT 0
`define ASR_STAT_LEVEL_BIT 0
`define ASR_STAT_ACTIVE_BIT 1
`define ASR_STAT_CAPPED_BIT 2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ASR_RST_WORD 16'h0000
`define ASR_RST_TARGET 2'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define ASR_CLK_PERIOD_NS 5
`define ASR_US_NS 1000
`define ASR_CYC_PER_US (`ASR_US_NS / `ASR_CLK_PERIOD_NS)
`define ASR_TIME_UNIT_US 100

`endif

/* File: asr_pkg.sv */
// types shared by the angle-synchronous shift register files
package asr_pkg;

    typedef enum {
        ASR_PATH_COMMON,
        ASR_PATH_SPLIT,
        ASR_PATH_TIME
    } asr_mode_t;

    typedef enum {
        ASR_LD_IDLE,
        ASR_LD_ON,
        ASR_LD_OFF
    } asr_lead_state_t;

    typedef enum logic [1:0] {
        ASR_TGT_PHYS = 2'h0,
        ASR_TGT_MARKER = 2'h1,
        ASR_TGT_EXT = 2'h2
    } asr_target_t;

endpackage

/* File: asr_divider.sv */
// sequential restoring divider, one quotient bit per clock
`timescale 1ns/10ps
module asr_divider #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [W-1:0] num,
    input wire logic [W-1:0] den,
    output logic done,
    output logic [W-1:0] quot
);
    logic [W-1:0] rem_q;
    logic [W-1:0] quo_q;
    logic [W-1:0] den_q;
    logic [$clog2(W):0] cnt_q;
    logic busy_q;
    logic done_q;

    wire [W:0] shifted = {rem_q, quo_q[W-1]};
    wire [W:0] diff = shifted - {1'b0, den_q};
    wire last = cnt_q == ($clog2(W)+1)'(W - 1);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rem_q <= '0;
            quo_q <= '0;
            den_q <= '0;
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (start && !busy_q) begin
            rem_q <= '0;
            quo_q <= num;
            den_q <= den;
            cnt_q <= '0;
            busy_q <= 1'b1;
            done_q <= 1'b0;
        end else if (busy_q) begin
            rem_q <= diff[W] ? shifted[W-1:0] : diff[W-1:0];
            quo_q <= {quo_q[W-2:0], ~diff[W]};
            cnt_q <= cnt_q + {{$clog2(W){1'b0}}, 1'b1};
            busy_q <= !last;
            done_q <= last;
        end else begin
            done_q <= 1'b0;
        end
    end

    assign done = done_q;
    assign quot = quo_q;
endmodule // asr_divider

/* File: asr_skid_buffer.sv */
// two-entry buffer with valid and ready on both sides, outputs from flip-flops
`timescale 1ns/10ps
module asr_skid_buffer #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic head_valid_q;
    logic [W-1:0] head_q;
    logic spare_valid_q;
    logic [W-1:0] spare_q;

    wire head_free = out_ready || !head_valid_q;
    wire take_in = in_valid && !spare_valid_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            head_valid_q <= 1'b0;
            head_q <= '0;
            spare_valid_q <= 1'b0;
            spare_q <= '0;
        end else if (head_free) begin
            // spare entry drains first so word order is kept
            head_valid_q <= spare_valid_q || in_valid;
            head_q <= spare_valid_q ? spare_q : in_data;
            spare_valid_q <= 1'b0;
        end else if (take_in) begin
            spare_valid_q <= 1'b1;
            spare_q <= in_data;
        end
    end

    assign in_ready = !spare_valid_q;
    assign out_valid = head_valid_q;
    assign out_data = head_q;
endmodule // asr_skid_buffer

/* File: asr_shift_top.sv */
// angle-synchronous shift register with speed-compensated output
`timescale 1ns/10ps
`include "asr_params.svh"
module asr_shift_top #(
    parameter asr_pkg::asr_mode_t MODE = asr_pkg::ASR_PATH_COMMON,
    parameter int DEPTH = 256
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic pos_step_fwd,
    input wire logic pos_step_rev,
    input wire logic link_bit,
    input wire logic slot_free,
    output logic out_phys,
    output logic out_marker,
    output logic out_ext,
    output logic evt_valid,
    output logic [15:0] evt_data,
    input wire logic evt_ready
);
    import asr_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam logic [15:0] DEPTH16 = 16'(DEPTH);
    localparam logic [7:0] CYC_LAST = 8'(`ASR_CYC_PER_US - 1);
    localparam logic [6:0] UNIT_LAST = 7'(`ASR_TIME_UNIT_US - 1);
    localparam logic [23:0] PER_MAX = 24'hffffff;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] umin16(input logic [15:0] a, input logic [15:0] b);
        umin16 = (a < b) ? a : b;
    endfunction

    // compensation in 0.1 ms units to microseconds
    function automatic logic [31:0] units_to_us(input logic [15:0] t);
        units_to_us = {16'h0000, t} * 32'(`ASR_TIME_UNIT_US);
    endfunction

    // lead in steps may never reach past the first cell
    function automatic logic [15:0] clamp_lead(input logic [31:0] q, input logic [15:0] elen);
        clamp_lead = (elen == 16'h0000) ? 16'h0000
                   : (q >= {16'h0000, elen}) ? elen - 16'h0001 : q[15:0];
    endfunction

    function automatic logic [AW-1:0] tap_index(input logic [15:0] elen, input logic [15:0] lead);
        logic [15:0] idx;
        idx = elen - 16'h0001 - lead;
        tap_index = idx[AW-1:0];
    endfunction

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic ctrl_en_q;
    logic [15:0] cap_q;
    logic [15:0] len_q;
    logic [15:0] comp_on_q;
    logic [15:0] comp_off_q;
    logic [15:0] on_time_q;
    logic [1:0] target_q;
    logic [15:0] rdata_q;

    wire wr_ctrl = reg_wr && reg_addr == `ASR_REG_CTRL;
    wire wr_cap = reg_wr && reg_addr == `ASR_REG_CAPACITY;
    wire wr_len = reg_wr && reg_addr == `ASR_REG_LENGTH;
    wire wr_comp_on = reg_wr && reg_addr == `ASR_REG_COMP_ON;
    wire wr_comp_off = reg_wr && reg_addr == `ASR_REG_COMP_OFF;
    wire wr_on_time = reg_wr && reg_addr == `ASR_REG_ON_TIME;
    wire wr_target = reg_wr && reg_addr == `ASR_REG_TARGET;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_en_q <= 1'b0;
            cap_q <= `ASR_RST_WORD;
            len_q <= `ASR_RST_WORD;
        end else begin
            if (wr_ctrl) ctrl_en_q <= reg_wdata[`ASR_CTRL_EN_BIT];
            if (wr_cap) cap_q <= reg_wdata;
            if (wr_len) len_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            comp_on_q <= `ASR_RST_WORD;
            comp_off_q <= `ASR_RST_WORD;
            on_time_q <= `ASR_RST_WORD;
            target_q <= `ASR_RST_TARGET;
        end else begin
            if (wr_comp_on) comp_on_q <= reg_wdata;
            if (wr_comp_off) comp_off_q <= reg_wdata;
            if (wr_on_time) on_time_q <= reg_wdata;
            // unknown range code is refused, keeping a legal target
            if (wr_target && reg_wdata[1:0] != 2'h3) target_q <= reg_wdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // length, capacity and availability
    // ------------------------------------------------------------------
    wire [15:0] eff_len = umin16(umin16(len_q, cap_q), DEPTH16);
    wire len_capped = len_q > eff_len;
    wire active = ctrl_en_q && (cap_q != 16'h0000) && slot_free && (eff_len != 16'h0000);

    // ------------------------------------------------------------------
    // time base: microsecond and 0.1 ms enables
    // ------------------------------------------------------------------
    logic [7:0] cyc_cnt_q;
    logic [6:0] us_cnt_q;

    wire us_tick = cyc_cnt_q == CYC_LAST;
    wire unit_tick = us_tick && us_cnt_q == UNIT_LAST;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cyc_cnt_q <= 8'h00;
            us_cnt_q <= 7'h00;
        end else begin
            cyc_cnt_q <= us_tick ? 8'h00 : cyc_cnt_q + 8'h01;
            if (us_tick) us_cnt_q <= (us_cnt_q == UNIT_LAST) ? 7'h00 : us_cnt_q + 7'h01;
        end
    end

    // ------------------------------------------------------------------
    // step decode and step period in microseconds
    // ------------------------------------------------------------------
    // both pulses at once cancel: net position did not move
    wire step_fwd = pos_step_fwd && !pos_step_rev;
    wire step_rev = pos_step_rev && !pos_step_fwd;
    wire any_step = step_fwd || step_rev;

    logic [23:0] per_cnt_q;
    logic [23:0] period_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            per_cnt_q <= 24'h000000;
            period_q <= PER_MAX;
        end else if (any_step) begin
            per_cnt_q <= 24'h000000;
            period_q <= per_cnt_q;
        end else if (us_tick && per_cnt_q != PER_MAX) begin
            per_cnt_q <= per_cnt_q + 24'h000001;
        end
    end

    // a running gap longer than the last period means slowing down
    wire [23:0] speed_per = (per_cnt_q > period_q) ? per_cnt_q : period_q;
    wire stopped = speed_per == PER_MAX;
    wire [31:0] div_den = {8'h00, (speed_per == 24'h000000) ? 24'h000001 : speed_per};

    // ------------------------------------------------------------------
    // lead calculation: compensation time over step period, in steps
    // ------------------------------------------------------------------
    asr_lead_state_t ld_state_q;
    logic [15:0] lead_on_q;
    logic [15:0] lead_off_q;
    logic div_done;
    logic [31:0] div_quot;

    // mode one reuses the switch-on figure for the switch-off edge
    wire [15:0] comp_off_sel = (MODE == ASR_PATH_SPLIT) ? comp_off_q : comp_on_q;
    wire div_start = (ld_state_q == ASR_LD_IDLE) || (ld_state_q == ASR_LD_ON && div_done);
    wire [31:0] div_num = units_to_us((ld_state_q == ASR_LD_IDLE) ? comp_on_q : comp_off_sel);
    wire [15:0] lead_new = stopped ? 16'h0000 : clamp_lead(div_quot, eff_len);

    asr_divider #(
        .W(32)
    ) u_div (
        .clk(clk),
        .arst_n(arst_n),
        .start(div_start),
        .num(div_num),
        .den(div_den),
        .done(div_done),
        .quot(div_quot)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ld_state_q <= ASR_LD_IDLE;
            lead_on_q <= 16'h0000;
            lead_off_q <= 16'h0000;
        end else begin
            unique case (ld_state_q)
                ASR_LD_IDLE: begin
                    ld_state_q <= ASR_LD_ON;
                end
                ASR_LD_ON: begin
                    if (div_done) begin
                        lead_on_q <= lead_new;
                        ld_state_q <= ASR_LD_OFF;
                    end
                end
                ASR_LD_OFF: begin
                    if (div_done) begin
                        lead_off_q <= lead_new;
                        ld_state_q <= ASR_LD_IDLE;
                    end
                end
            endcase
        end
    end

    // leads are clamped again here so a shortened length takes effect before the next update pass
    wire [15:0] lead_on_use = clamp_lead({16'h0000, lead_on_q}, eff_len);
    wire [15:0] lead_off_use = clamp_lead({16'h0000, lead_off_q}, eff_len);

    // ------------------------------------------------------------------
    // shift cells
    // ------------------------------------------------------------------
    logic [DEPTH-1:0] cells_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cells_q <= '0;
        end else if (!active) begin
            cells_q <= '0;
        end else if (step_fwd) begin
            cells_q <= {cells_q[DEPTH-2:0], link_bit};
        end else if (step_rev) begin
            // last cell repeats so a short reversal loses no product
            cells_q <= {cells_q[DEPTH-1], cells_q[DEPTH-1:1]};
        end
    end

    // ------------------------------------------------------------------
    // output taps and switching
    // ------------------------------------------------------------------
    wire tap_on = cells_q[tap_index(eff_len, lead_on_use)];
    wire tap_off = cells_q[tap_index(eff_len, lead_off_use)];

    logic tap_on_q;
    logic tap_off_q;
    logic level_q;
    logic [15:0] hold_q;

    wire rise_on = tap_on && !tap_on_q;
    wire fall_off = !tap_off && tap_off_q;
    wire hold_done = hold_q == 16'h0000;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tap_on_q <= 1'b0;
            tap_off_q <= 1'b0;
        end else begin
            tap_on_q <= tap_on;
            tap_off_q <= tap_off;
        end
    end

    // in split mode, an off tap ahead of the on tap leaves the level
    // undefined; the set below simply wins in that case
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            level_q <= 1'b0;
            hold_q <= 16'h0000;
        end else if (!active) begin
            level_q <= 1'b0;
            hold_q <= 16'h0000;
        end else if (MODE == ASR_PATH_TIME) begin
            if (rise_on) begin
                level_q <= 1'b1;
                hold_q <= on_time_q;
            end else if (level_q && hold_done) begin
                level_q <= 1'b0;
            end else if (level_q && unit_tick) begin
                hold_q <= hold_q - 16'h0001;
            end
        end else if (rise_on) begin
            level_q <= 1'b1;
        end else if (fall_off) begin
            level_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // target range outputs
    // ------------------------------------------------------------------
    logic out_phys_q;
    logic out_marker_q;
    logic out_ext_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_phys_q <= 1'b0;
            out_marker_q <= 1'b0;
            out_ext_q <= 1'b0;
        end else begin
            out_phys_q <= level_q && target_q == ASR_TGT_PHYS;
            out_marker_q <= level_q && target_q == ASR_TGT_MARKER;
            out_ext_q <= level_q && target_q == ASR_TGT_EXT;
        end
    end

    assign out_phys = out_phys_q;
    assign out_marker = out_marker_q;
    assign out_ext = out_ext_q;

    // ------------------------------------------------------------------
    // edge event stream
    // ------------------------------------------------------------------
    // one pending event; while the buffer is full a newer edge merges
    // into it, so the receiver always sees the latest level
    logic level_seen_q;
    logic evt_pend_q;
    logic [14:0] step_cnt_q;
    logic buf_in_ready;

    wire level_edge = level_q != level_seen_q;
    wire evt_take = evt_pend_q && buf_in_ready;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            level_seen_q <= 1'b0;
            evt_pend_q <= 1'b0;
            step_cnt_q <= 15'h0000;
        end else begin
            level_seen_q <= level_q;
            // a new edge in the accept cycle keeps the event pending
            evt_pend_q <= level_edge || (evt_pend_q && !evt_take);
            if (step_fwd) step_cnt_q <= step_cnt_q + 15'h0001;
            if (step_rev) step_cnt_q <= step_cnt_q - 15'h0001;
        end
    end

    asr_skid_buffer #(
        .W(16)
    ) u_evt_buf (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(evt_pend_q),
        .in_ready(buf_in_ready),
        .in_data({level_q, step_cnt_q}),
        .out_valid(evt_valid),
        .out_ready(evt_ready),
        .out_data(evt_data)
    );

    // ------------------------------------------------------------------
    // read path, data one cycle after the strobe
    // ------------------------------------------------------------------
    wire [15:0] status_word = {13'h0000, len_capped, active, level_q};
    wire [15:0] rd_mux =
        (reg_addr == `ASR_REG_CTRL) ? {15'h0000, ctrl_en_q} :
        (reg_addr == `ASR_REG_CAPACITY) ? cap_q :
        (reg_addr == `ASR_REG_LENGTH) ? len_q :
        (reg_addr == `ASR_REG_COMP_ON) ? comp_on_q :
        (reg_addr == `ASR_REG_COMP_OFF) ? comp_off_q :
        (reg_addr == `ASR_REG_ON_TIME) ? on_time_q :
        (reg_addr == `ASR_REG_TARGET) ? {14'h0000, target_q} :
        (reg_addr == `ASR_REG_STATUS) ? status_word :
        (reg_addr == `ASR_REG_PERIOD) ? speed_per[15:0] :
        (reg_addr == `ASR_REG_LEAD_ON) ? lead_on_use :
        (reg_addr == `ASR_REG_LEAD_OFF) ? lead_off_use : 16'h0000;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    assign reg_rdata = rdata_q;
endmodule // asr_shift_top

/* File: asr_shift_chk_assertions.sv */
// port-level checks for the angle-synchronous shift register top
`timescale 1ns/10ps
module asr_shift_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic slot_free,
    input wire logic out_phys,
    input wire logic out_marker,
    input wire logic out_ext,
    input wire logic evt_valid,
    input wire logic [15:0] evt_data,
    input wire logic evt_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic any_out = out_phys | out_marker | out_ext;
    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("read data not zero outside read answer");
    a_rd_unmapped: assert property (reg_rd && reg_addr > 4'ha |=> reg_rdata == 16'h0)
        else $error("unmapped read returned data");
    a_rd_ctrl: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[15:1] == 15'h0)
        else $error("control read has stray bits");
    a_rd_status: assert property (reg_rd && reg_addr == 4'h7 |=> reg_rdata[15:3] == 13'h0)
        else $error("status read has stray bits");
    a_rd_target: assert property (reg_rd && reg_addr == 4'h6 |=> reg_rdata[15:2] == 14'h0)
        else $error("target read has stray bits");
    // ----------------------------------------------------------------
    // outputs and events
    // ----------------------------------------------------------------
    a_one_target: assert property ($onehot0({out_phys, out_marker, out_ext}))
        else $error("more than one output target driven");
    a_slot_gone: assert property (!slot_free [*4] |-> !any_out)
        else $error("output active without a free slot");
    a_evt_hold: assert property (evt_valid && !evt_ready |=> evt_valid && $stable(evt_data))
        else $error("event word dropped or changed while stalled");
    c_out_on: cover property ($rose(out_marker));
    c_evt_stall: cover property (evt_valid && !evt_ready);
    c_slot_off: cover property ($fell(slot_free) && any_out);
endmodule // asr_shift_chk

bind asr_shift_top asr_shift_chk u_chk (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slot_free(slot_free),
    .out_phys(out_phys), .out_marker(out_marker), .out_ext(out_ext),
    .evt_valid(evt_valid), .evt_data(evt_data), .evt_ready(evt_ready));

/* File: asr_pos_model.sv */
// far-side model: position step source and logic network result
`timescale 1ns/10ps
module asr_pos_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [1:0] cmd,
    input wire logic cmd_bit,
    output logic pos_step_fwd,
    output logic pos_step_rev,
    output logic link_bit
);
    // cam sits at its true position, so the bit carries no compensation of its own
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pos_step_fwd <= 1'b0;
            pos_step_rev <= 1'b0;
            link_bit <= 1'b0;
        end else begin
            pos_step_fwd <= cmd == 2'h1;
            pos_step_rev <= cmd == 2'h2;
            link_bit <= cmd_bit;
        end
    end
endmodule // asr_pos_model

/* File: asr_shift_top_tb_top.sv */
// self-checking bench for the angle-synchronous shift register
`timescale 1ns/10ps
`include "asr_params.svh"
module asr_shift_top_tb_top;
    logic clk = 0;
    logic arst_n = 0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic slot_free = 1;
    logic evt_ready = 0;
    logic cmd_bit = 0;
    logic [1:0] cmd = 2'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic [15:0] reg_rdata, evt_data, v;
    logic pos_step_fwd, pos_step_rev, link_bit, out_phys, out_marker, out_ext, evt_valid;
    int failures = 0;
    int checked = 0;
    int cycles = 0;

    initial begin
        forever #2.5 clk = ~clk;
    end

    asr_shift_top dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pos_step_fwd(pos_step_fwd), .pos_step_rev(pos_step_rev), .link_bit(link_bit),
        .slot_free(slot_free), .out_phys(out_phys), .out_marker(out_marker),
        .out_ext(out_ext), .evt_valid(evt_valid), .evt_data(evt_data),
        .evt_ready(evt_ready));
    asr_pos_model u_pos (.clk(clk), .arst_n(arst_n), .cmd(cmd), .cmd_bit(cmd_bit),
        .pos_step_fwd(pos_step_fwd), .pos_step_rev(pos_step_rev), .link_bit(link_bit));

    // second copy in path-time mode, same stimulus; on time stays zero
    logic out_marker_t;
    asr_shift_top #(.MODE(asr_pkg::ASR_PATH_TIME)) dut_t (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(), .pos_step_fwd(pos_step_fwd), .pos_step_rev(pos_step_rev),
        .link_bit(link_bit), .slot_free(slot_free), .out_phys(), .out_marker(out_marker_t),
        .out_ext(), .evt_valid(), .evt_data(), .evt_ready(evt_ready));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    // waits well past the three-edge path from step to output
    task automatic step(input logic [1:0] c, input logic b);
        @(posedge clk);
        cmd <= c;
        cmd_bit <= b;
        @(posedge clk);
        cmd <= 2'h0;
        repeat (6) @(posedge clk);
    endtask

    task automatic load3();
        step(2'h1, 1'b1);
        step(2'h1, 1'b0);
        step(2'h1, 1'b0);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        rd(`ASR_REG_PERIOD, v);
        chk(v, 16'hffff);
        rd(`ASR_REG_TARGET, v);
        chk(v, 16'h0);
        wr(`ASR_REG_TARGET, 16'h1);
        wr(`ASR_REG_TARGET, 16'h3);
        rd(`ASR_REG_TARGET, v);
        chk(v, 16'h1);
        wr(4'hf, 16'h5a5a);
        rd(4'hf, v);
        chk(v, 16'h0);
        wr(`ASR_REG_CTRL, 16'h1);
        wr(`ASR_REG_CAPACITY, 16'h8);
        wr(`ASR_REG_LENGTH, 16'ha);
        rd(`ASR_REG_STATUS, v);
        chk(v[2], 1'b1);
        wr(`ASR_REG_LENGTH, 16'h3);
        rd(`ASR_REG_STATUS, v);
        chk(v[2], 1'b0);
        step(2'h1, 1'b1);
        step(2'h1, 1'b0);
        chk(out_marker, 1'b0);
        step(2'h1, 1'b0);
        chk({out_phys, out_marker, out_ext}, 3'b010);
        chk(out_marker_t, 1'b0);
        chk(evt_valid, 1'b1);
        chk(evt_data[15], 1'b1);
        evt_ready <= 1'b1;
        repeat (4) @(posedge clk);
        chk(evt_valid, 1'b0);
        step(2'h2, 1'b0);
        step(2'h1, 1'b0);
        chk(out_marker, 1'b1);
        step(2'h1, 1'b0);
        chk(out_marker, 1'b0);
        load3();
        chk(out_marker, 1'b1);
        slot_free <= 1'b0;
        repeat (4) @(posedge clk);
        chk(out_marker, 1'b0);
        slot_free <= 1'b1;
        wr(`ASR_REG_CAPACITY, 16'h0);
        load3();
        chk(out_marker, 1'b0);
        wr(`ASR_REG_CAPACITY, 16'h8);
        wr(`ASR_REG_COMP_ON, 16'h1);
        // lead far beyond the length must clamp to one short of it
        repeat (100) @(posedge clk);
        rd(`ASR_REG_LEAD_ON, v);
        chk(v, 16'h2);
        rd(`ASR_REG_COMP_ON, v);
        chk(v, 16'h1);
        finish_test();
    end
endmodule // asr_shift_top_tb_top
